// file: rtl/early_irq_pkg.sv
// Constants shared by the early interrupt timing block.
package early_irq_pkg;
  localparam int DIV_W           = 7;
  localparam int LEAD_W          = 3;
  localparam int CONV_CYCLES     = 12;
  localparam int CNT_W           = 5;
  localparam int RESERVED_HI_BIT = 13;
  localparam int EARLY_EN_BIT    = 12;
  localparam int RESERVED_LO_BIT = 11;
  localparam int LEAD_LSB        = 8;
  localparam int LEAD_MSB        = 10;
  localparam logic [DIV_W-1:0] DIV_RESET  = 7'h00;
  localparam logic [LEAD_W-1:0] LEAD_RESET = 3'h0;
endpackage

// file: rtl/core_clock_divider.sv
// Divider that makes the conversion core clock enable from the source clock.
`timescale 1ns/1ps
`default_nettype none
module core_clock_divider #(
  parameter int DIV_W = early_irq_pkg::DIV_W
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic [DIV_W-1:0] shared_core_clock_divider,
  output logic                  core_tick
);
  logic [DIV_W:0] count;
  wire  [DIV_W:0] period_m1;
  wire            wrap;

  // Code n gives 2n source periods, code 0 is taken as one period.
  assign period_m1 = (shared_core_clock_divider == '0) ? '0
                   : {shared_core_clock_divider, 1'b0} - {{DIV_W{1'b0}}, 1'b1};
  assign wrap = (count >= period_m1);

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      count     <= '0;
      core_tick <= 1'b0;
    end
    else
    begin
      count     <= wrap ? '0 : count + 1'b1;
      core_tick <= wrap;
    end
  end
endmodule
`default_nettype wire

// file: rtl/adc_early_interrupt_timing.sv
// Early and normal conversion interrupt timing for the shared converter core.
`timescale 1ns/1ps
`default_nettype none
module adc_early_interrupt_timing #(
  parameter int DIV_W       = early_irq_pkg::DIV_W,
  parameter int LEAD_W      = early_irq_pkg::LEAD_W,
  parameter int CONV_CYCLES = early_irq_pkg::CONV_CYCLES
) (
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              early_irq_enable,
  input  wire logic [LEAD_W-1:0] shared_early_lead_select,
  input  wire logic [DIV_W-1:0]  shared_core_clock_divider,
  input  wire logic              conversion_start,
  input  wire logic              flag_clear,
  output logic                   busy,
  output logic                   channel_early_status_flag,
  output logic                   channel_data_ready_flag,
  output logic                   conversion_irq
);
  typedef enum logic [0:0] {IDLE, CONVERT} conv_state_t;

  conv_state_t                      state;
  conv_state_t                      next_state;
  logic [early_irq_pkg::CNT_W-1:0]  remaining;
  logic [LEAD_W-1:0]                lead_hold;
  logic                             core_tick;
  logic                             early_hold;
  wire  [early_irq_pkg::CNT_W-1:0]  lead_periods;
  wire                              early_hit;
  wire                              ready_hit;
  wire                              irq_event;

  core_clock_divider #(
    .DIV_W (DIV_W)
  ) u_div (
    .mclk                      (mclk),
    .sys_rst                   (sys_rst),
    .shared_core_clock_divider (shared_core_clock_divider),
    .core_tick                 (core_tick)
  );

  // Lead is latched at start so a mid-conversion change cannot skip the early point.
  // Ready is taken on the tick where one period remains, so the early point sits
  // lead plus one ticks above that, which keeps code 000 one whole period ahead.
  assign lead_periods = {{(early_irq_pkg::CNT_W-LEAD_W){1'b0}}, lead_hold}
                      + {{(early_irq_pkg::CNT_W-2){1'b0}}, 2'b10};
  // Counting only on core ticks keeps the lead in whole core periods.
  assign early_hit = (state == CONVERT) && core_tick && (remaining == lead_periods);
  assign ready_hit = (state == CONVERT) && core_tick
                   && (remaining == {{(early_irq_pkg::CNT_W-1){1'b0}}, 1'b1});
  // Interrupt source follows the enable.
  assign irq_event = early_hold ? early_hit : ready_hit;

  always_comb
  begin
    next_state = state;
    unique case (state)
      IDLE:    if (conversion_start) next_state = CONVERT;
      CONVERT: if (ready_hit) next_state = IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state      <= IDLE;
      remaining  <= '0;
      lead_hold  <= early_irq_pkg::LEAD_RESET;
      early_hold <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (state == IDLE && conversion_start)
      begin
        remaining  <= early_irq_pkg::CNT_W'(CONV_CYCLES);
        lead_hold  <= shared_early_lead_select;
        early_hold <= early_irq_enable;
      end
      else if (state == CONVERT && core_tick)
        remaining <= remaining - 1'b1;
    end
  end

  // Flags are sticky; a set in the clearing cycle wins.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      channel_early_status_flag <= 1'b0;
      channel_data_ready_flag   <= 1'b0;
      conversion_irq            <= 1'b0;
    end
    else
    begin
      channel_early_status_flag <= early_hit | (channel_early_status_flag & ~flag_clear);
      channel_data_ready_flag   <= ready_hit | (channel_data_ready_flag & ~flag_clear);
      conversion_irq            <= irq_event;
    end
  end

  assign busy = (state == CONVERT);
endmodule
`default_nettype wire

// file: sim/adc_early_irq_asserts.sv
// Timing assertions for the early interrupt block.
`timescale 1ns/1ps
`default_nettype none
module adc_early_irq_asserts (
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic       early_irq_enable,
  input wire logic [2:0] shared_early_lead_select,
  input wire logic [6:0] shared_core_clock_divider,
  input wire logic       channel_early_status_flag,
  input wire logic       channel_data_ready_flag,
  input wire logic       conversion_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire logic e0 = shared_early_lead_select == 3'h0;
  property p_irq_early; $rose(channel_early_status_flag) && early_irq_enable |-> conversion_irq; endproperty
  a_irq_early: assert property (p_irq_early) else $error("early irq missing");
  property p_irq_ready; $rose(channel_data_ready_flag) && !early_irq_enable |-> conversion_irq; endproperty
  a_irq_ready: assert property (p_irq_ready) else $error("ready irq missing");
  property p_lead_max; $rose(channel_early_status_flag) && shared_early_lead_select == 3'h7 && shared_core_clock_divider == 7'h00 |-> ##8 $rose(channel_data_ready_flag); endproperty
  a_lead_max: assert property (p_lead_max) else $error("lead 8 wrong");
  property p_lead_min; $rose(channel_early_status_flag) && e0 && shared_core_clock_divider == 7'h00 |=> $rose(channel_data_ready_flag); endproperty
  a_lead_min: assert property (p_lead_min) else $error("lead 1 wrong");
  property p_div_max; $rose(channel_early_status_flag) && e0 && shared_core_clock_divider == 7'h7f |-> ##254 $rose(channel_data_ready_flag); endproperty
  a_div_max: assert property (p_div_max) else $error("period 254 wrong");
  property p_div_exact; $rose(channel_early_status_flag) && shared_early_lead_select == 3'h1 && shared_core_clock_divider == 7'h01 |-> ##4 $rose(channel_data_ready_flag); endproperty
  a_div_exact: assert property (p_div_exact) else $error("divided lead wrong");
  c_early: cover property (conversion_irq && early_irq_enable);
  c_ready: cover property (conversion_irq && !early_irq_enable);
  c_slow: cover property (channel_data_ready_flag && shared_core_clock_divider == 7'h7f);
endmodule
bind adc_early_interrupt_timing adc_early_irq_asserts u_adc_early_irq_asserts (.mclk, .sys_rst,
  .early_irq_enable, .shared_early_lead_select, .shared_core_clock_divider,
  .channel_early_status_flag, .channel_data_ready_flag, .conversion_irq);
`default_nettype wire

// file: sim/adc_early_interrupt_timing_tb.sv
// Self-checking bench for the early interrupt timing block.
`timescale 1ns/1ps
`default_nettype none
module adc_early_interrupt_timing_tb;
  logic       mclk = 0, sys_rst = 1, early_irq_enable = 0, conversion_start = 0, flag_clear = 0;
  logic [2:0] shared_early_lead_select = 3'h0;
  logic [6:0] shared_core_clock_divider = 7'h00;
  logic       busy, channel_early_status_flag, channel_data_ready_flag, conversion_irq;
  int         error_cnt = 0, cmp_count = 0;
  adc_early_interrupt_timing u_adc_early_interrupt_timing (.mclk, .sys_rst, .early_irq_enable,
    .shared_early_lead_select, .shared_core_clock_divider, .conversion_start, .flag_clear,
    .busy, .channel_early_status_flag, .channel_data_ready_flag, .conversion_irq);
  initial forever #20 mclk = ~mclk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Divider and lead stay put for the whole conversion, since the divider is read live.
  task automatic run(input logic en, input logic [2:0] sel, input logic [6:0] div);
    int t = 0, te = 0, ti = 0, ni = 0;
    // Enable, lead and divider are driven; reserved control positions have no port.
    early_irq_enable <= en;
    shared_early_lead_select <= sel;
    shared_core_clock_divider <= div;
    conversion_start <= 1'b1;
    @(posedge mclk);
    conversion_start <= 1'b0;
    #1;
    check(busy, 1'b1);
    while (channel_data_ready_flag !== 1'b1 && t < 5000)
    begin
      @(posedge mclk);
      #1;
      t++;
      if (channel_early_status_flag === 1'b1 && te == 0) te = t;
      if (conversion_irq === 1'b1) ni++;
      if (conversion_irq === 1'b1) ti = t;
    end
    if (t >= 5000) error_cnt++;
    if (t >= 5000) complete_run();
    check(t - te, (sel + 1) * (div == 7'h00 ? 1 : 2 * div));
    check(ti, en ? te : t);
    check(ni, 1);
    check(busy, 1'b0);
    @(posedge mclk);
    flag_clear <= 1'b1;
    @(posedge mclk);
    flag_clear <= 1'b0;
    $display("test done en %0d sel %0d div %0d", en, sel, div);
  endtask
  initial
  begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 8; i++) run(i[0], i[2:0], 7'h00);
    run(1'b1, 3'h1, 7'h01);
    run(1'b1, 3'h0, 7'h7f);
    complete_run();
  end
endmodule
`default_nettype wire
